/* hdl/csc_consts.svh */
// constants for the command sequence controller
`ifndef CSC_CONSTS_SVH
`define CSC_CONSTS_SVH
`define CSC_ADDR_W 16
`define CSC_OP_W 6
`define CSC_CM_BASE 16'h0000
`define CSC_CM_LAST 16'h00ff
`define CSC_BOOT_BASE 16'hff00
`define CSC_BOOT_LAST 16'hffff
`define CSC_INT_VECTOR 16'h0100
`define CSC_OP_ADDK 6'h39
`define CSC_OP_FMT2 6'h28
`define CSC_BUFSEL_LO 6'h09
`define CSC_BUFSEL_HI 6'h0b
`define CSC_PH_FIRST 4'h0
`define CSC_PH_LAST 4'hf
`define CSC_PH_T31 4'h9
`define CSC_PH_MEM 4'h3
`endif

/* hdl/csc_pkg.sv */
// types for the command sequence controller
`default_nettype none
package csc_pkg;
  typedef enum logic [3:0] {
    SEQ_IDLE = 4'b0000,
    SEQ_FETCH = 4'b0001,
    SEQ_RD1 = 4'b0010,
    SEQ_RD2 = 4'b0011,
    SEQ_WR = 4'b0100,
    SEQ_BUF1 = 4'b0101,
    SEQ_BUF2 = 4'b0110,
    SEQ_IO1 = 4'b0111,
    SEQ_IO2 = 4'b1000
  } csc_seq_t;
  // the plan an instruction carries: which sequences follow fetch
  typedef struct packed {
    logic rd1;
    logic rd2;
    logic wr;
    logic buf_setup;
    logic finish_in_next;
  } csc_plan_t;
  // memory request toward control memory, main memory or boot store
  typedef struct packed {
    logic strobe;
    logic write;
    logic to_ctrl;
    logic to_boot;
    logic [15:0] addr;
  } csc_mreq_t;
endpackage : csc_pkg
`default_nettype wire

/* hdl/csc_timing_chain.sv */
// main timing chain: sixteen cycle.phase pulses per sequence
`timescale 1ns/1ps
`default_nettype none
`include "csc_consts.svh"
module csc_timing_chain
  import csc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // control
  input wire logic run_i,
  // phase outputs
  output logic [3:0] phase_o,
  output logic [15:0] pulse_o,
  output logic last_o
);
  logic [3:0] next_phase;

  // count while a sequence is selected; index 0 is 4.4, 15 is 4.3
  always_comb begin
    next_phase = phase_o;
    if (run_i) begin
      next_phase = phase_o + 4'h1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      phase_o <= `CSC_PH_FIRST;
    end else begin
      phase_o <= next_phase;
    end
  end

  // one-hot decode of the current phase
  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_pulse
      assign pulse_o[g] = run_i && (phase_o == 4'(g));
    end
  endgenerate

  assign last_o = run_i && (phase_o == `CSC_PH_LAST);

  chk_wrap_to_first: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    last_o |=> phase_o == `CSC_PH_FIRST)
    else $error("phase did not wrap after 4.3");
endmodule : csc_timing_chain
`default_nettype wire

/* hdl/csc_sequencer.sv */
// command sequence controller: picks and runs sequences per instruction
// Contract
// - Sixteen timing pulses, 4.4 then 1.1 through 4.3, run per sequence.
// - Sequences follow a fixed order per instruction, at most four.
// - Every instruction starts with the fetch sequence reading its word.
// - Instructions needing a memory operand run one or two read sequences.
// - The write sequence stores the result to the given location.
// - Buffer setup ops copy the next two words to control memory and arm.
// - First transfer sequence reads, compares unless in continuous transfer mode, writes back, moves a word.
// - Second transfer runs only in dual or link mode when ending a buffer.
// - An interrupt runs beside fetch and forces a fixed address.
// - Commands fire at set phases, conditional ones only when true.
// - At 3.1 of fetch for op 71 the lower accumulator feeds the selector.
// - Control memory addresses, buffer setup and first transfer go to control memory, all else to main.
// - In fixed boot mode, boot addresses return their fixed contents.
// - In main memory mode, shadowed addresses are ordinary main memory.
// - Some instructions finish during the next instruction's fetch.
`timescale 1ns/1ps
`default_nettype none
`include "csc_consts.svh"
module csc_sequencer
  import csc_pkg::*;
#(
  parameter int ADDR_W = `CSC_ADDR_W
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // control and modes
  input wire logic run_i,
  input wire logic fixed_boot_store_i,
  input wire logic dual_mode_i,
  input wire logic external_link_mode_i,
  input wire logic continuous_transfer_mode_i,
  // events
  input wire logic fault_int_i,
  input wire logic io_int_i,
  input wire logic io_request_i,
  input wire logic buf_terminate_i,
  // decoded instruction, valid in fetch from phase 3.1
  input wire logic [5:0] opcode_i,
  input wire logic [ADDR_W-1:0] operand_addr_i,
  input wire csc_plan_t plan_i,
  // memory request
  output csc_mreq_t mreq_o,
  // sequence and timing state
  output csc_seq_t seq_o,
  output logic [3:0] phase_o,
  output logic [15:0] pulse_o,
  // commands
  output logic al_to_selector_o,
  output logic finish_prev_o,
  output logic buf_arm_o,
  output logic io_compare_o,
  output logic io_writeback_o,
  output logic int_active_o
);
  // sequence state
  csc_seq_t seq;
  csc_seq_t next_seq;
  csc_plan_t plan;
  csc_plan_t next_plan;
  logic [ADDR_W-1:0] pc;
  logic [ADDR_W-1:0] next_pc;
  logic [ADDR_W-1:0] maddr;
  logic [ADDR_W-1:0] next_maddr;
  logic int_pend;
  logic next_int_pend;
  logic io_pend;
  logic next_io_pend;
  logic finish_pend;
  logic next_finish_pend;
  logic last;
  logic running;

  assign running = (seq != SEQ_IDLE);

  csc_timing_chain csc_timing_chain_inst (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .run_i(running),
    .phase_o(phase_o),
    .pulse_o(pulse_o),
    .last_o(last)
  );

  // address for the memory phase of each sequence; reads and the write
  // keep the operand caught at 3.1, the rest follow the new counter
  always_comb begin
    next_maddr = maddr;
    if (seq == SEQ_IDLE) begin
      next_maddr = pc;
    end else if (last && next_seq != SEQ_RD1 && next_seq != SEQ_RD2
                 && next_seq != SEQ_WR) begin
      next_maddr = next_pc;
    end
    if (seq == SEQ_FETCH && pulse_o[`CSC_PH_T31]) begin
      next_maddr = operand_addr_i;
    end
  end

  // sequence selection: fixed order fetch, reads, write, buffer, transfer
  always_comb begin
    next_seq = seq;
    next_plan = plan;
    next_pc = pc;
    // events set wins over the clear on the same edge
    next_int_pend = int_pend | fault_int_i | io_int_i;
    next_io_pend = io_pend | io_request_i;
    next_finish_pend = finish_pend;
    if (seq == SEQ_IDLE) begin
      if (run_i) begin
        next_seq = SEQ_FETCH;
      end
    end else if (last) begin
      case (seq)
        SEQ_FETCH: begin
          next_plan = plan_i;
          next_finish_pend = plan_i.finish_in_next;
          if (int_pend) begin
            next_int_pend = fault_int_i | io_int_i;
          end
          if (plan_i.buf_setup && opcode_i == `CSC_OP_FMT2) begin
            next_seq = SEQ_BUF1;
          end else if (plan_i.rd1) begin
            next_seq = SEQ_RD1;
          end else if (plan_i.wr) begin
            next_seq = SEQ_WR;
          end else begin
            next_seq = SEQ_FETCH;
          end
          next_pc = int_pend ? ADDR_W'(`CSC_INT_VECTOR)
                    : pc + ADDR_W'(1);
        end
        SEQ_RD1: begin
          next_seq = plan.rd2 ? SEQ_RD2 : (plan.wr ? SEQ_WR : SEQ_FETCH);
        end
        SEQ_RD2: begin
          next_seq = plan.wr ? SEQ_WR : SEQ_FETCH;
        end
        SEQ_BUF1: begin
          next_seq = SEQ_BUF2;
          next_pc = pc + ADDR_W'(1);
        end
        SEQ_BUF2: begin
          next_seq = SEQ_FETCH;
          next_pc = pc + ADDR_W'(1);
        end
        SEQ_IO1: begin
          next_io_pend = io_request_i;
          next_seq = ((dual_mode_i || external_link_mode_i) && buf_terminate_i)
                     ? SEQ_IO2 : SEQ_FETCH;
        end
        default: begin
          next_seq = SEQ_FETCH;
        end
      endcase
      // transfer requests slot in ahead of the next fetch
      if (next_seq == SEQ_FETCH && io_pend && seq != SEQ_IO1) begin
        next_seq = SEQ_IO1;
      end
      if (!run_i && next_seq == SEQ_FETCH) begin
        next_seq = SEQ_IDLE;
      end
      if (seq == SEQ_FETCH && !plan_i.finish_in_next && finish_pend) begin
        next_finish_pend = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      seq <= SEQ_IDLE;
      plan <= '0;
      pc <= '0;
      maddr <= '0;
      int_pend <= 1'b0;
      io_pend <= 1'b0;
      finish_pend <= 1'b0;
    end else begin
      seq <= next_seq;
      plan <= next_plan;
      pc <= next_pc;
      maddr <= next_maddr;
      int_pend <= next_int_pend;
      io_pend <= next_io_pend;
      finish_pend <= next_finish_pend;
    end
  end

  // memory request and command decode at fixed phases
  csc_mreq_t next_mreq;
  logic next_al_sel;
  logic next_finish;
  logic next_arm;
  logic next_cmp;
  logic next_wb;
  logic in_cm;
  logic in_boot;

  always_comb begin
    in_cm = (maddr >= `CSC_CM_BASE) && (maddr <= `CSC_CM_LAST);
    in_boot = (maddr >= `CSC_BOOT_BASE) && (maddr <= `CSC_BOOT_LAST);
    next_mreq = '0;
    next_mreq.strobe = running && pulse_o[`CSC_PH_MEM];
    next_mreq.write = (seq == SEQ_WR) || (seq == SEQ_BUF1)
                      || (seq == SEQ_BUF2);
    next_mreq.addr = 16'(maddr);
    next_mreq.to_ctrl = in_cm || (seq == SEQ_BUF1) || (seq == SEQ_BUF2)
                        || (seq == SEQ_IO1);
    // boot reads only; main memory mode leaves the range ordinary
    next_mreq.to_boot = in_boot && fixed_boot_store_i
                        && !next_mreq.write;
    next_al_sel = (seq == SEQ_FETCH) && pulse_o[`CSC_PH_T31]
                  && (opcode_i == `CSC_OP_ADDK);
    next_finish = (seq == SEQ_FETCH) && finish_pend
                  && pulse_o[1];
    next_arm = (seq == SEQ_BUF2) && last;
    next_cmp = (seq == SEQ_IO1) && pulse_o[`CSC_PH_T31]
               && !continuous_transfer_mode_i;
    next_wb = (seq == SEQ_IO1) && pulse_o[12];
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      mreq_o <= '0;
      al_to_selector_o <= 1'b0;
      finish_prev_o <= 1'b0;
      buf_arm_o <= 1'b0;
      io_compare_o <= 1'b0;
      io_writeback_o <= 1'b0;
      int_active_o <= 1'b0;
    end else begin
      mreq_o <= next_mreq;
      al_to_selector_o <= next_al_sel;
      finish_prev_o <= next_finish;
      buf_arm_o <= next_arm;
      io_compare_o <= next_cmp;
      io_writeback_o <= next_wb;
      int_active_o <= int_pend && (seq == SEQ_FETCH);
    end
  end

  assign seq_o = seq;

  chk_seq_holds_phase: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (running && !last) |=> seq == $past(seq))
    else $error("sequence changed before its last phase");
  chk_io2_cond: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (seq != SEQ_IO2 ##1 seq == SEQ_IO2) |-> $past(seq) == SEQ_IO1)
    else $error("second transfer not after first");
  chk_addk_select: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (seq == SEQ_FETCH && phase_o == `CSC_PH_T31 && opcode_i == `CSC_OP_ADDK)
    |=> al_to_selector_o)
    else $error("lower accumulator not routed at 3.1");
  chk_ctrl_route: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (mreq_o.strobe && mreq_o.addr <= `CSC_CM_LAST) |-> mreq_o.to_ctrl)
    else $error("control address sent to main memory");
  chk_boot_route: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    mreq_o.to_boot |-> $past(fixed_boot_store_i))
    else $error("boot store used in main memory mode");
  chk_buf_pair: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (seq == SEQ_BUF1 && last) |=> seq == SEQ_BUF2)
    else $error("buffer setup did not take two words");
  chk_rd_after: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (seq == SEQ_RD2) |-> ##[0:15] (seq == SEQ_RD2 && last))
    else $error("read sequence overran");
  chk_start_fetch: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (seq == SEQ_IDLE && run_i) |=> seq == SEQ_FETCH)
    else $error("instruction did not begin with fetch");
endmodule : csc_sequencer
`default_nettype wire

/* testbench/csc_mem_model.sv */
// memory side model: counts requests the stores would refuse
`timescale 1ns/1ps
`default_nettype none
module csc_mem_model
  import csc_pkg::*;
(
  // clock and request
  input wire logic clk_sys_i,
  input wire csc_mreq_t mreq_i,
  // refused request count
  output var int bad_o
);
  int bad = 0;

  // boot words are fixed and the regions never overlap
  always @(posedge clk_sys_i) begin
    if (mreq_i.strobe === 1'b1) begin
      if (mreq_i.to_boot && (mreq_i.write || mreq_i.to_ctrl)) begin
        bad <= bad + 1;
      end
    end
  end

  // one driver for the count seen by the bench
  assign bad_o = bad;
endmodule : csc_mem_model
`default_nettype wire

/* testbench/csc_sequencer_tb_top.sv */
// self-checking bench for the command sequence controller
`timescale 1ns/1ps
`default_nettype none
`include "csc_consts.svh"
module csc_sequencer_tb_top
  import csc_pkg::*;
;
  logic clk, rst, run, fb, dual, ext, ctm, fint, ioint, ioreq, term;
  logic [5:0] op;
  logic [15:0] addr, pul, last_a;
  csc_plan_t plan;
  csc_mreq_t mreq;
  csc_seq_t seq;
  logic [3:0] ph;
  logic sel, fin, arm, cmp, wb, ia;
  int bad, n_errors, checks;
  logic [15:0] c_sel, c_fin, c_arm, c_cmp, c_wb, c_int, c_stb, c_wr;
  logic [15:0] c_ctl, c_boot;

  csc_sequencer csc_sequencer_inst (.clk_sys_i(clk), .rst_i(rst),
    .run_i(run), .fixed_boot_store_i(fb), .dual_mode_i(dual),
    .external_link_mode_i(ext), .continuous_transfer_mode_i(ctm),
    .fault_int_i(fint), .io_int_i(ioint), .io_request_i(ioreq),
    .buf_terminate_i(term), .opcode_i(op), .operand_addr_i(addr),
    .plan_i(plan), .mreq_o(mreq), .seq_o(seq), .phase_o(ph),
    .pulse_o(pul), .al_to_selector_o(sel), .finish_prev_o(fin),
    .buf_arm_o(arm), .io_compare_o(cmp), .io_writeback_o(wb),
    .int_active_o(ia));
  csc_mem_model csc_mem_model_inst (.clk_sys_i(clk), .mreq_i(mreq),
    .bad_o(bad));

  // free running system clock
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, exp, input string m);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // short reset clears sticky events, then run until fetch starts
  task automatic start(input logic [5:0] o, input csc_plan_t p,
    input logic [15:0] a);
    @(posedge clk) #1;
    rst = 1;
    op = o;
    plan = p;
    addr = a;
    repeat (2) @(posedge clk);
    #1 rst = 0;
    run = 1;
    {c_sel, c_fin, c_arm, c_cmp, c_wb, c_int, c_stb, c_wr} = '0;
    for (int i = 0; i < 20 && seq === SEQ_IDLE; i++) @(posedge clk) #1;
  endtask : start

  // one sequence window of sixteen phases, tallying commands
  task automatic seq_chk(input csc_seq_t s);
    for (int i = 0; i < 16; i++) begin
      chk(16'(seq), 16'(s), "sequence");
      chk(16'(ph), 16'(i), "phase");
      chk(pul, 16'h1 << i, "pulse");
      c_sel += 16'(sel);
      c_fin += 16'(fin);
      c_arm += 16'(arm);
      c_cmp += 16'(cmp);
      c_wb += 16'(wb);
      c_int += 16'(ia);
      if (mreq.strobe === 1'b1) begin
        c_stb++;
        c_wr += 16'(mreq.write);
        c_ctl += 16'(mreq.to_ctrl);
        c_boot += 16'(mreq.to_boot);
        last_a = mreq.addr;
      end
      @(posedge clk) #1;
    end
  endtask : seq_chk

  task automatic s_fetch();
    start(`CSC_OP_ADDK, 5'b00001, 16'h1234);
    seq_chk(SEQ_FETCH);
    chk(c_stb, 16'h1, "fetch read");
    chk(c_sel, 16'h1, "selector");
    chk(c_fin, 16'h0, "early finish");
    seq_chk(SEQ_FETCH);
    chk(c_fin, 16'h1, "finish in fetch");
  endtask : s_fetch

  task automatic s_rw();
    start(6'h02, 5'b11100, 16'h1234);
    seq_chk(SEQ_FETCH);
    seq_chk(SEQ_RD1);
    seq_chk(SEQ_RD2);
    seq_chk(SEQ_WR);
    chk(c_stb, 16'h4, "accesses");
    chk(c_wr, 16'h1, "writes");
    chk(c_sel, 16'h0, "selector off");
    seq_chk(SEQ_FETCH);
  endtask : s_rw

  task automatic s_buf();
    start(`CSC_OP_FMT2, 5'b00010, 16'h0000);
    seq_chk(SEQ_FETCH);
    seq_chk(SEQ_BUF1);
    seq_chk(SEQ_BUF2);
    chk(c_stb, 16'h3, "two words");
    // the arm pulse lands in the first cycle after the second word
    seq_chk(SEQ_FETCH);
    chk(c_arm, 16'h1, "arm");
  endtask : s_buf

  // mode table: continuous, dual, link, terminate, second transfer expected
  task automatic s_io();
    logic [4:0] t[5] = '{5'b11011, 5'b01011, 5'b00111, 5'b01000, 5'b00010};
    foreach (t[k]) begin
      {ctm, dual, ext, term} = t[k][4:1];
      start(6'h02, 5'b00000, 16'h0000);
      fork
        begin
          ioreq = 1;
          @(posedge clk) #1 ioreq = 0;
        end
      join_none
      seq_chk(SEQ_FETCH);
      seq_chk(SEQ_IO1);
      chk(c_cmp, 16'(!t[k][4]), "compare");
      chk(c_wb, 16'h1, "write back");
      seq_chk(t[k][0] ? SEQ_IO2 : SEQ_FETCH);
    end
  endtask : s_io

  task automatic s_int();
    for (int k = 0; k < 2; k++) begin
      start(6'h02, 5'b00000, 16'h0000);
      fork
        begin
          {fint, ioint} = k ? 2'b01 : 2'b10;
          @(posedge clk) #1 {fint, ioint} = 2'b00;
        end
      join_none
      seq_chk(SEQ_FETCH);
      chk(16'(c_int != 0), 16'h1, "interrupt");
      seq_chk(SEQ_FETCH);
      chk(last_a, `CSC_INT_VECTOR, "vector");
    end
  endtask : s_int

  // route table: boot mode, address, control count; boot count expected for the first entry only
  task automatic s_route();
    logic [17:0] t[4] = '{{1'b1, 16'hff00, 1'b0}, {1'b0, 16'hff00, 1'b0},
      {1'b0, 16'h0010, 1'b1}, {1'b1, 16'h1234, 1'b0}};
    foreach (t[k]) begin
      fb = t[k][17];
      start(6'h02, 5'b10000, t[k][16:1]);
      seq_chk(SEQ_FETCH);
      {c_ctl, c_boot} = '0;
      seq_chk(SEQ_RD1);
      chk(c_ctl, 16'(t[k][0]), "control");
      chk(c_boot, 16'(k == 0), "boot");
    end
  endtask : s_route

  task automatic end_of_test();
    chk(16'(bad), 16'h0, "refused access");
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test

  // main sequence; long reset at start, short ones per scenario
  initial begin
    {rst, run, fb, dual, ext, ctm, fint, ioint, ioreq, term} = 10'h200;
    op = '0;
    addr = '0;
    plan = '0;
    n_errors = 0;
    checks = 0;
    {c_ctl, c_boot} = '0;
    repeat (8) @(posedge clk);
    #1 rst = 0;
    s_fetch();
    s_rw();
    s_buf();
    s_io();
    s_int();
    s_route();
    end_of_test();
  end

  // run is about 670 cycles; far past that counts as a hang
  initial begin
    #100us;
    n_errors++;
    end_of_test();
  end
endmodule : csc_sequencer_tb_top
`default_nettype wire
